// file: rtl/clk_delay_sync_pkg.sv
// package of register map, field layout and reset values for the clock delay and sync register bank
package clk_delay_sync_pkg;
	localparam int reg_width = 16;
	localparam int reg_index_coarse = 12;
	localparam int reg_index_fine = 13;
	localparam int reg_index_sync = 14;
	localparam int reg_index_fixed = 15;
	localparam logic [7:0] addr_coarse = 8'h30;
	localparam logic [7:0] addr_fine = 8'h34;
	localparam logic [7:0] addr_sync = 8'h38;
	localparam logic [7:0] addr_fixed = 8'h3c;
	localparam logic [15:0] reset_coarse = 16'h0004;
	localparam logic [15:0] reset_fine = 16'h0000;
	localparam logic [15:0] reset_sync = 16'h0003;
	localparam logic [15:0] fixed_word = 16'h001d;
	localparam int coarse_lsb = 4;
	localparam int coarse_bits = 12;
	localparam int aperture_sel_bit = 3;
	localparam int duty_cycle_bit = 2;
	localparam int fine_lsb = 10;
	localparam int fine_bits = 6;
	localparam int refdly_lsb = 7;
	localparam int refdly_bits = 9;
	localparam int quad_bit = 6;
	localparam int phase_lsb = 3;
	localparam int secondary_bit = 2;
	localparam int out_disable_bit = 1;
	localparam int reset_block_bit = 0;
	localparam logic [11:0] coarse_max_code = 12'h097f;
	localparam logic [8:0] refdly_max_code = 9'h13f;
	localparam logic [15:0] coarse_write_mask = 16'hfffc;
	localparam logic [15:0] fine_write_mask = 16'hfc00;
	localparam logic [15:0] sync_write_mask = 16'hffdf;
	localparam logic [1:0] resp_okay = 2'b00;
	localparam logic [1:0] resp_slverr = 2'b10;
	typedef enum logic [1:0] {phase_0, phase_90, phase_180, phase_270} phase_type;
endpackage : clk_delay_sync_pkg

// file: rtl/refclk_divider.sv
// reference clock output divider: sample clock divided by four, or by two in power save mode
module refclk_divider
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// control
	input wire logic out_disable,
	input wire logic low_sample_power_save_mode,
	// outputs
	output logic reference_clock_output_1,
	output logic reference_clock_output_2
);
	logic [1:0] count_q;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			count_q <= 2'h0;
		else
			count_q <= count_q + 2'h1;
	end

	// registered so both outputs switch on the same edge with no glitches
	always_ff @(posedge aclk)
	begin
		if (!aresetn || out_disable)
		begin
			reference_clock_output_1 <= 1'b0;
			reference_clock_output_2 <= 1'b0;
		end
		else
		begin
			reference_clock_output_1 <= low_sample_power_save_mode ? count_q[0] : count_q[1];
			reference_clock_output_2 <= low_sample_power_save_mode ? count_q[0] : count_q[1];
		end
	end

	out_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
		out_disable |=> !reference_clock_output_1 && !reference_clock_output_2)
		else $error("reference outputs toggle while disabled");
endmodule : refclk_divider

// file: rtl/clk_delay_sync_regs.sv
// axi4-lite register bank for aperture delay, duty cycle stabilizer and multi-device sync
//
// Implementation choice: the AXI4-Lite interface to the registers.
module clk_delay_sync_regs
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// device status inputs
	input wire logic low_sample_power_save_mode,
	input wire logic data_clock_reset_input,
	// aperture delay controls
	output logic [11:0] coarse_delay_applied,
	output logic [5:0] fine_delay_applied,
	output logic duty_cycle_correct_en,
	// sync controls
	output logic [8:0] refclk_delay_applied,
	output logic [1:0] refclk_phase_select,
	output logic dual_edge_quadrature_mode,
	output logic secondary_sync_en,
	output logic data_clock_reset_pulse,
	output logic reference_clock_output_1,
	output logic reference_clock_output_2
);
	logic [15:0] coarse_q;
	logic [15:0] fine_q;
	logic [15:0] sync_q;
	logic [7:0] awaddr_q;
	logic aw_held_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic w_held_q;
	logic do_write;
	logic [1:0] pss_sync_q;
	logic [1:0] rst_sync_q;
	logic rst_prev_q;

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] data,
		input logic [3:0] strb, input logic [15:0] mask);
		logic [15:0] v;
		v = old;
		if (strb[0])
			v[7:0] = data[7:0];
		if (strb[1])
			v[15:8] = data[15:8];
		merge = (v & mask) | (old & ~mask);
	endfunction : merge

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == clk_delay_sync_pkg::addr_coarse) || (a == clk_delay_sync_pkg::addr_fine)
			|| (a == clk_delay_sync_pkg::addr_sync) || (a == clk_delay_sync_pkg::addr_fixed);
	endfunction : mapped

	// address and data are held separately so they may arrive in either order
	assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
	assign s_axi_wready = !w_held_q && !s_axi_bvalid;
	assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_q <= 1'b0;
			awaddr_q <= 8'h00;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_held_q <= 1'b1;
			awaddr_q <= s_axi_awaddr;
		end
		else if (do_write)
			aw_held_q <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_held_q <= 1'b0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_held_q <= 1'b1;
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
		end
		else if (do_write)
			w_held_q <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= clk_delay_sync_pkg::resp_okay;
		end
		else if (do_write)
		begin
			s_axi_bvalid <= 1'b1;
			// the fixed word answers okay but keeps its pattern
			s_axi_bresp <= mapped(awaddr_q) ? clk_delay_sync_pkg::resp_okay : clk_delay_sync_pkg::resp_slverr;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// reserved bits are masked so a careless write cannot disturb them
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			coarse_q <= clk_delay_sync_pkg::reset_coarse;
		else if (do_write && awaddr_q == clk_delay_sync_pkg::addr_coarse)
			coarse_q <= merge(coarse_q, wdata_q, wstrb_q, clk_delay_sync_pkg::coarse_write_mask);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			fine_q <= clk_delay_sync_pkg::reset_fine;
		else if (do_write && awaddr_q == clk_delay_sync_pkg::addr_fine)
			fine_q <= merge(fine_q, wdata_q, wstrb_q, clk_delay_sync_pkg::fine_write_mask);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			sync_q <= clk_delay_sync_pkg::reset_sync;
		else if (do_write && awaddr_q == clk_delay_sync_pkg::addr_sync)
			sync_q <= merge(sync_q, wdata_q, wstrb_q, clk_delay_sync_pkg::sync_write_mask);
	end

	// the fixed word has no storage, so writes to it have no effect
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= clk_delay_sync_pkg::resp_okay;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= clk_delay_sync_pkg::resp_okay;
			unique case (s_axi_araddr)
				clk_delay_sync_pkg::addr_coarse: s_axi_rdata <= {16'h0000, coarse_q};
				clk_delay_sync_pkg::addr_fine: s_axi_rdata <= {16'h0000, fine_q};
				clk_delay_sync_pkg::addr_sync: s_axi_rdata <= {16'h0000, sync_q};
				clk_delay_sync_pkg::addr_fixed: s_axi_rdata <= {16'h0000, clk_delay_sync_pkg::fixed_word};
				default:
				begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= clk_delay_sync_pkg::resp_slverr;
				end
			endcase
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	assign s_axi_arready = !s_axi_rvalid;

	// aperture delay decode
	logic [11:0] coarse_code;
	logic [5:0] fine_code;
	logic aperture_sel;
	assign coarse_code = coarse_q[clk_delay_sync_pkg::coarse_lsb +: clk_delay_sync_pkg::coarse_bits];
	assign fine_code = fine_q[clk_delay_sync_pkg::fine_lsb +: clk_delay_sync_pkg::fine_bits];
	assign aperture_sel = coarse_q[clk_delay_sync_pkg::aperture_sel_bit];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			coarse_delay_applied <= 12'h000;
			fine_delay_applied <= 6'h00;
			duty_cycle_correct_en <= 1'b1;
		end
		else
		begin
			if (!aperture_sel)
				coarse_delay_applied <= 12'h000;
			else if (coarse_code > clk_delay_sync_pkg::coarse_max_code)
				coarse_delay_applied <= clk_delay_sync_pkg::coarse_max_code;
			else
				coarse_delay_applied <= coarse_code;
			fine_delay_applied <= aperture_sel ? fine_code : 6'h00;
			duty_cycle_correct_en <= coarse_q[clk_delay_sync_pkg::duty_cycle_bit];
		end
	end

	// sync decode
	logic [8:0] refdly_code;
	assign refdly_code = sync_q[clk_delay_sync_pkg::refdly_lsb +: clk_delay_sync_pkg::refdly_bits];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			refclk_delay_applied <= 9'h000;
			refclk_phase_select <= 2'b00;
			dual_edge_quadrature_mode <= 1'b0;
			secondary_sync_en <= 1'b0;
		end
		else
		begin
			refclk_delay_applied <= (refdly_code >= clk_delay_sync_pkg::refdly_max_code)
				? clk_delay_sync_pkg::refdly_max_code : refdly_code;
			refclk_phase_select <= sync_q[clk_delay_sync_pkg::phase_lsb +: 2];
			dual_edge_quadrature_mode <= sync_q[clk_delay_sync_pkg::quad_bit];
			secondary_sync_en <= sync_q[clk_delay_sync_pkg::secondary_bit];
		end
	end

	// pin inputs pass two flip-flops before use
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pss_sync_q <= 2'b00;
			rst_sync_q <= 2'b00;
			rst_prev_q <= 1'b0;
		end
		else
		begin
			pss_sync_q <= {pss_sync_q[0], low_sample_power_save_mode};
			rst_sync_q <= {rst_sync_q[0], data_clock_reset_input};
			rst_prev_q <= rst_sync_q[1];
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			data_clock_reset_pulse <= 1'b0;
		else
			data_clock_reset_pulse <= rst_sync_q[1] && !rst_prev_q
				&& !sync_q[clk_delay_sync_pkg::reset_block_bit];
	end

	refclk_divider refclk_divider_i
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.out_disable(sync_q[clk_delay_sync_pkg::out_disable_bit]),
		.low_sample_power_save_mode(pss_sync_q[1]),
		.reference_clock_output_1(reference_clock_output_1),
		.reference_clock_output_2(reference_clock_output_2)
	);

	// decoded controls trail the register by one cycle
	coarse_sat_a: assert property (@(posedge aclk) disable iff (!aresetn)
		coarse_delay_applied <= clk_delay_sync_pkg::coarse_max_code)
		else $error("coarse delay above maximum");
	coarse_cap_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(aperture_sel && coarse_code >= 12'h0980) |=> coarse_delay_applied == 12'h097f)
		else $error("coarse delay not held at maximum");
	coarse_track_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(aperture_sel && coarse_code < 12'h0980) |=> coarse_delay_applied == $past(coarse_code))
		else $error("coarse delay does not follow code");
	aperture_on_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(aperture_sel && coarse_code != 12'h000) |=> coarse_delay_applied != 12'h000)
		else $error("coarse delay missing while aperture adjust on");
	aperture_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!aperture_sel |=> coarse_delay_applied == 12'h000 && fine_delay_applied == 6'h00)
		else $error("delay applied while aperture adjust off");
	fine_track_a: assert property (@(posedge aclk) disable iff (!aresetn)
		aperture_sel |=> fine_delay_applied == $past(fine_code))
		else $error("fine delay does not follow code");
	refdly_sat_a: assert property (@(posedge aclk) disable iff (!aresetn)
		refdly_code >= 9'h13f |=> refclk_delay_applied == 9'h13f)
		else $error("reference delay not saturated");
	refdly_track_a: assert property (@(posedge aclk) disable iff (!aresetn)
		refdly_code < 9'h13f |=> refclk_delay_applied == $past(refdly_code))
		else $error("reference delay does not follow code");
	refdly_cap_a: assert property (@(posedge aclk) disable iff (!aresetn)
		refclk_delay_applied <= 9'h13f)
		else $error("reference delay above maximum");
	fixed_word_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h3c) |=> s_axi_rdata == 32'h0000_001d)
		else $error("fixed word read wrong");
	fixed_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h3c) |=> s_axi_rresp == 2'b00)
		else $error("fixed word read refused");
	coarse_resv_a: assert property (@(posedge aclk) disable iff (!aresetn)
		coarse_q[1:0] == 2'b00)
		else $error("coarse reserved bits set");
	reset_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
		sync_q[0] |=> !data_clock_reset_pulse)
		else $error("data clock reset while blocked");
	pulse_enable_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(rst_sync_q[1] && !rst_prev_q && !sync_q[0]) |=> data_clock_reset_pulse)
		else $error("data clock reset edge lost");
	pulse_single_a: assert property (@(posedge aclk) disable iff (!aresetn)
		data_clock_reset_pulse |=> !data_clock_reset_pulse)
		else $error("data clock reset pulse too long");
	role_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
		1'b1 |=> secondary_sync_en == $past(sync_q[2]) && refclk_phase_select == $past(sync_q[4:3]))
		else $error("sync role or phase not applied");
	quad_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
		1'b1 |=> dual_edge_quadrature_mode == $past(sync_q[6]))
		else $error("quadrature mode not applied");
	duty_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
		1'b1 |=> duty_cycle_correct_en == $past(coarse_q[2]))
		else $error("duty cycle enable not applied");
	refout_pair_a: assert property (@(posedge aclk) disable iff (!aresetn)
		reference_clock_output_1 == reference_clock_output_2)
		else $error("reference outputs differ");

	// a full write lands as written, less only the reserved bits
	coarse_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(do_write && awaddr_q == 8'h30 && wstrb_q[1:0] == 2'b11) |=> coarse_q[15:2] == $past(wdata_q[15:2]))
		else $error("coarse write not stored");
	fine_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(do_write && awaddr_q == 8'h34 && wstrb_q[1]) |=> fine_q[15:10] == $past(wdata_q[15:10]))
		else $error("fine write not stored");
	sync_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(do_write && awaddr_q == 8'h38 && wstrb_q[1:0] == 2'b11)
		|=> sync_q[15:6] == $past(wdata_q[15:6]) && sync_q[4:0] == $past(wdata_q[4:0]))
		else $error("sync write not stored");
	fixed_nowrite_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(do_write && awaddr_q == 8'h3c) |=> $stable(coarse_q) && $stable(fine_q) && $stable(sync_q))
		else $error("write to fixed word changed a register");
endmodule : clk_delay_sync_regs

// file: sim/testbench.sv
// self-checking bench for the clock delay and sync register bank
`define chk(nm, exp, got) checks++; if ((got) !== (exp)) begin failures++; $display("unexpected %s exp %h got %h", nm, exp, got); end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] wstrb = 4'h0;
	logic power_save = 1'b0, reset_pin = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, dqm, sec, duty, pulse, ro1, ro2;
	logic [1:0] bresp, rresp, phase;
	logic [31:0] rdata;
	logic [11:0] coarse;
	logic [5:0] fine;
	logic [8:0] refdly;
	int failures = 0, checks = 0, n;
	logic [1:0] wq[$];
	logic [33:0] rq[$];
	logic [1:0] wexp;
	logic [33:0] rexp;
	logic [11:0] c;
	logic [8:0] d;
	clk_delay_sync_regs clk_delay_sync_regs_i (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.low_sample_power_save_mode(power_save), .data_clock_reset_input(reset_pin),
		.coarse_delay_applied(coarse), .fine_delay_applied(fine), .duty_cycle_correct_en(duty),
		.refclk_delay_applied(refdly), .refclk_phase_select(phase), .dual_edge_quadrature_mode(dqm),
		.secondary_sync_en(sec), .data_clock_reset_pulse(pulse),
		.reference_clock_output_1(ro1), .reference_clock_output_2(ro2));
	initial
	begin
		forever #10 aclk = ~aclk;
	end
	// response monitor: each answer is matched against the oldest note
	// the note is popped once, so a mismatch cannot consume a second note
	always @(posedge aclk)
	begin
		if (bvalid && bready)
		begin
			if (wq.size() == 0)
			begin
				failures++;
				$display("unexpected bresp exp none got %h", bresp);
			end
			else
			begin
				wexp = wq.pop_front();
				`chk("bresp", wexp, bresp)
			end
		end
		if (rvalid && rready)
		begin
			if (rq.size() == 0)
			begin
				failures++;
				$display("unexpected rresp rdata exp none got %h", {rresp, rdata});
			end
			else
			begin
				rexp = rq.pop_front();
				`chk("rresp rdata", rexp, {rresp, rdata})
			end
		end
	end
	// waits for the answer however long it takes; only the watchdog ends a hang
	task automatic wr(input logic [7:0] a, input logic [15:0] dat, input logic [1:0] r);
		@(posedge aclk);
		wq.push_back(r);
		awaddr <= a;
		wdata <= {16'h0000, dat};
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end
		while (!(bvalid && bready));
		bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [15:0] exp, input logic [1:0] r);
		@(posedge aclk);
		rq.push_back({r, 16'h0000, exp});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
		end
		while (!(rvalid && rready));
		rready <= 1'b0;
	endtask : rd
	// decoded outputs trail the register by a cycle, so let them land
	task automatic settle();
		repeat (3) @(posedge aclk);
	endtask : settle
	task automatic done(input string nm);
		$display("test %s finished", nm);
	endtask : done
	task automatic close_out();
		// a note still waiting means a response never came
		failures += wq.size() + rq.size();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : close_out
	initial
	begin
		repeat (20000) @(posedge aclk);
		failures++;
		close_out();
	end
	initial
	begin
		void'($urandom(32'hd52293e7));
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		rd(clk_delay_sync_pkg::addr_coarse, 16'h0004, clk_delay_sync_pkg::resp_okay);
		rd(clk_delay_sync_pkg::addr_fine, 16'h0000, clk_delay_sync_pkg::resp_okay);
		rd(clk_delay_sync_pkg::addr_sync, 16'h0003, clk_delay_sync_pkg::resp_okay);
		rd(clk_delay_sync_pkg::addr_fixed, 16'h001d, clk_delay_sync_pkg::resp_okay);
		`chk("duty reset", 1'b1, duty)
		`chk("refout reset", 2'b00, {ro1, ro2})
		done("reset");
		// delay fields held but not applied while select is low
		wr(clk_delay_sync_pkg::addr_coarse, 16'h5a54, clk_delay_sync_pkg::resp_okay);
		wr(clk_delay_sync_pkg::addr_fine, 16'hfc00, clk_delay_sync_pkg::resp_okay);
		settle();
		`chk("coarse off", 12'h000, coarse)
		`chk("fine off", 6'h00, fine)
		for (int i = 0; i < 5; i++)
		begin
			c = (i == 0) ? 12'($urandom_range(2430)) : (i == 1) ? 12'd2431 : (i == 2) ? 12'd2432 : (i == 3) ? 12'hfff : 12'd0;
			wr(clk_delay_sync_pkg::addr_coarse, {c, 1'b1, i[0], 2'b00}, clk_delay_sync_pkg::resp_okay);
			rd(clk_delay_sync_pkg::addr_coarse, {c, 1'b1, i[0], 2'b00}, clk_delay_sync_pkg::resp_okay);
			settle();
			`chk("coarse applied", (c > 12'd2431) ? 12'd2431 : c, coarse)
			`chk("duty", i[0], duty)
			`chk("fine on", 6'h3f, fine)
		end
		done("aperture");
		for (int i = 0; i < 4; i++)
		begin
			d = (i == 0) ? 9'd318 : (i == 1) ? 9'd319 : (i == 2) ? 9'd320 : 9'($urandom_range(511, 321));
			wr(clk_delay_sync_pkg::addr_sync, {d, i[0], 1'b0, i[1:0], i[1], 2'b11}, clk_delay_sync_pkg::resp_okay);
			settle();
			`chk("refdly", (d > 9'd319) ? 9'd319 : d, refdly)
			`chk("phase", i[1:0], phase)
			`chk("quad", i[0], dqm)
			`chk("secondary", i[1], sec)
		end
		done("sync fields");
		// reset pin is ignored while the block bit is set
		reset_pin <= 1'b1;
		n = 0;
		repeat (10) @(posedge aclk) n += pulse;
		reset_pin <= 1'b0;
		`chk("pulse blocked", 0, n)
		wr(clk_delay_sync_pkg::addr_sync, 16'h0000, clk_delay_sync_pkg::resp_okay);
		settle();
		reset_pin <= 1'b1;
		n = 0;
		repeat (10) @(posedge aclk) n += pulse;
		`chk("pulse count", 1, n)
		done("data clock reset");
		for (int i = 0; i < 2; i++)
		begin
			@(posedge aclk);
			power_save <= i[0];
			repeat (8) @(posedge aclk);
			// first sample taken here so a level already high is not counted as a rise
			#1;
			c[0] = ro1;
			n = 0;
			repeat (16)
			begin
				@(posedge aclk);
				#1;
				n += (ro1 && !c[0]);
				c[0] = ro1;
				`chk("refout pair", ro1, ro2)
			end
			`chk("refout rises", i ? 8 : 4, n)
		end
		done("reference outputs");
		wr(clk_delay_sync_pkg::addr_fixed, 16'hffff, clk_delay_sync_pkg::resp_okay);
		rd(clk_delay_sync_pkg::addr_fixed, 16'h001d, clk_delay_sync_pkg::resp_okay);
		wr(8'h40, 16'h1234, clk_delay_sync_pkg::resp_slverr);
		rd(8'h40, 16'h0000, clk_delay_sync_pkg::resp_slverr);
		repeat (4) @(posedge aclk);
		done("fixed and unmapped");
		close_out();
	end
endmodule : testbench
